// ===== lfpc_defs.vh
/*
  lfpc_defs.vh: constants for the flash pin-control block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef LFPC_DEFS_VH
`define LFPC_DEFS_VH
`define LFPC_START_OK 4'h0
`define LFPC_CT_MEM_RD 4'h4
`define LFPC_CT_MEM_WR 4'h6
`define LFPC_ADDR_NIBBLES 4'h8
`define LFPC_AMEM_BIT 22
`define LFPC_ID_HI_MSB 24
`define LFPC_ID_HI_LSB 23
`define LFPC_ID_LO_MSB 21
`define LFPC_ID_LO_LSB 20
`define LFPC_MEM_AW 20
`define LFPC_TOP_BLK_MSB 19
`define LFPC_TOP_BLK_LSB 16
`define LFPC_TOP_BLK_VAL 4'hF
`define LFPC_ST_IDLE 3'h0
`define LFPC_ST_CTYPE 3'h1
`define LFPC_ST_ADDR 3'h2
`define LFPC_ST_DATA 3'h3
`define LFPC_ST_TAR 3'h4
`define LFPC_ST_RSP 3'h5
`define LFPC_GPI_REG_SEL 4'h0
`endif

// ===== lfpc_sync.v
/*
  lfpc_sync.v: two-flop synchroniser for a bundle of pin levels.
  Assumes levels from outside the clock domain; reset value is zero.
*/
`timescale 1ns/100ps
`default_nettype none
module lfpc_sync #(
  parameter W = 1
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== lfpc_top.v
/*
  lfpc_top.v: pin-level control of a byte-wide flash with a low-pin-count
  host port and a parallel programmer port: mode, reset merge, select,
  standby, identity strap, board inputs, hardware write protection.
  Assumes i_sys_clk is the bus clock from the host; all pins are async.
*/
// Operation
// - mode input high selects programmer port, low selects bus port
// - init and reset inputs merge; either low resets identically
// - main reset resets both bus and programmer interface logic
// - four-bit strapped identity identifies this part on a shared bus
// - five board inputs readable by the host via register read
// - top-lock low refuses programming of top boot block
// - write-protect low refuses programming outside top block
// - frame assertion starts a transfer and aborts any cycle
// - chip select low enables device; high means low-power standby
// - row/column select steers muxed address to row or column
// - four address/data lines carry control, address and data both ways
// - control unit clocked by host-supplied bus clock
// - address field carries identity and memory/register select
// - top-lock and write-protect protections act independently
// - operation valid only if latched start value is all zeros
`timescale 1ns/100ps
`default_nettype none
`include "lfpc_defs.vh"
module lfpc_top #(
  parameter PP_AW = 11
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_init_n,
  input wire i_programmer_port_mode,
  input wire i_ce_n,
  input wire i_frame_n,
  input wire [3:0] i_lad,
  input wire [3:0] i_chip_strap,
  input wire [4:0] i_board_inputs,
  input wire i_top_block_lock_n,
  input wire i_wp_n,
  input wire i_row_col_n,
  input wire [PP_AW-1:0] i_pp_addr,
  output reg [3:0] o_lad,
  output reg o_lad_oe_n,
  output reg o_standby,
  output reg o_pp_active,
  output reg o_wr_start,
  output reg [`LFPC_MEM_AW-1:0] o_wr_addr,
  output reg [7:0] o_wr_data,
  output reg o_wr_refused,
  output reg [2*PP_AW-1:0] o_pp_addr
);
  // reset pins combined before anything else sees them
  wire rst_n = i_rst_n & i_init_n;
  wire [19+PP_AW-1:0] s;
  lfpc_sync #(.W(19+PP_AW)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_async({i_programmer_port_mode, i_ce_n, i_frame_n, i_lad, i_chip_strap,
      i_board_inputs, i_top_block_lock_n, i_wp_n, i_row_col_n, i_pp_addr}),
    .o_sync(s)
  );
  wire pp_s = s[PP_AW+18];
  wire ce_n_s = s[PP_AW+17];
  wire frame_n_s = s[PP_AW+16];
  wire [3:0] lad_s = s[PP_AW+15:PP_AW+12];
  wire [3:0] strap_s = s[PP_AW+11:PP_AW+8];
  wire [4:0] gpi_s = s[PP_AW+7:PP_AW+3];
  wire tbl_n_s = s[PP_AW+2];
  wire wp_n_s = s[PP_AW+1];
  wire rc_n_s = s[PP_AW];
  wire [PP_AW-1:0] ppa_s = s[PP_AW-1:0];

  reg mode_q;
  reg mode_taken_q;
  reg [1:0] fill_q;
  reg [3:0] strap_q;
  reg [2:0] st_q;
  reg [3:0] start_q;
  reg is_wr_q;
  reg [3:0] cnt_q;
  reg [31:0] addr_q;
  reg [7:0] data_q;
  reg [3:0] rsp_q;
  // bus side stays shut until the synchronised mode and strap have been caught
  wire lpc_on = mode_taken_q & ~mode_q & ~ce_n_s;

  // mode and strap are caught once after reset release; later pin moves are ignored
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= 1'b0;
      mode_taken_q <= 1'b0;
      strap_q <= 4'h0;
      fill_q <= 2'h0;
    end
    else if (!mode_taken_q)
    begin
      // the synchroniser shows its reset value for two edges after release
      if (fill_q == 2'h2)
      begin
        mode_q <= pp_s;
        strap_q <= strap_s;
        mode_taken_q <= 1'b1;
      end
      else
      begin
        fill_q <= fill_q + 2'h1;
      end
    end
  end

  wire id_hit = {addr_q[`LFPC_ID_HI_MSB:`LFPC_ID_HI_LSB],
    addr_q[`LFPC_ID_LO_MSB:`LFPC_ID_LO_LSB]} == strap_q;
  wire is_mem = addr_q[`LFPC_AMEM_BIT];
  wire top_blk = addr_q[`LFPC_TOP_BLK_MSB:`LFPC_TOP_BLK_LSB] == `LFPC_TOP_BLK_VAL;
  // each lock covers its own region only
  wire prot = top_blk ? ~tbl_n_s : ~wp_n_s;

  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= `LFPC_ST_IDLE;
      start_q <= 4'hF;
      is_wr_q <= 1'b0;
      cnt_q <= 4'h0;
      addr_q <= 32'h0000_0000;
      data_q <= 8'h00;
      rsp_q <= 4'h0;
      o_lad <= 4'h0;
      o_lad_oe_n <= 1'b1;
      o_wr_start <= 1'b0;
      o_wr_addr <= {`LFPC_MEM_AW{1'b0}};
      o_wr_data <= 8'h00;
      o_wr_refused <= 1'b0;
    end
    else
    begin
      o_wr_start <= 1'b0;
      o_wr_refused <= 1'b0;
      if (!lpc_on)
      begin
        st_q <= `LFPC_ST_IDLE;
        o_lad_oe_n <= 1'b1;
      end
      else if (!frame_n_s)
      begin
        // frame low: latch start nibble, abort anything running
        start_q <= lad_s;
        st_q <= `LFPC_ST_IDLE;
        o_lad_oe_n <= 1'b1;
      end
      else
      begin
        case (st_q)
          `LFPC_ST_IDLE:
          begin
            // the nibble seen as frame rises is already the cycle type
            is_wr_q <= lad_s[1];
            cnt_q <= 4'h0;
            if (start_q == `LFPC_START_OK &&
              (lad_s == `LFPC_CT_MEM_RD || lad_s == `LFPC_CT_MEM_WR))
            begin
              st_q <= `LFPC_ST_ADDR;
            end
            start_q <= 4'hF;
          end
          `LFPC_ST_ADDR:
          begin
            addr_q <= {addr_q[27:0], lad_s};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `LFPC_ADDR_NIBBLES - 4'h1)
            begin
              cnt_q <= 4'h0;
              st_q <= is_wr_q ? `LFPC_ST_DATA : `LFPC_ST_TAR;
            end
          end
          `LFPC_ST_DATA:
          begin
            // data arrives low nibble first
            data_q <= {lad_s, data_q[7:4]};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h1)
            begin
              if (id_hit && is_mem)
              begin
                o_wr_start <= ~prot;
                o_wr_refused <= prot;
                o_wr_addr <= addr_q[`LFPC_MEM_AW-1:0];
                o_wr_data <= {lad_s, data_q[7:4]};
              end
              st_q <= `LFPC_ST_IDLE;
            end
          end
          `LFPC_ST_TAR:
          begin
            rsp_q <= gpi_s[3:0];
            if (id_hit && !is_mem && addr_q[3:0] == `LFPC_GPI_REG_SEL)
            begin
              st_q <= `LFPC_ST_RSP;
              cnt_q <= 4'h0;
            end
            else
            begin
              st_q <= `LFPC_ST_IDLE;
            end
          end
          `LFPC_ST_RSP:
          begin
            // sync, low nibble, high nibble of the board-input byte
            o_lad_oe_n <= 1'b0;
            cnt_q <= cnt_q + 4'h1;
            case (cnt_q)
              4'h0: o_lad <= 4'h0;
              4'h1: o_lad <= rsp_q;
              4'h2: o_lad <= {3'h0, gpi_s[4]};
              default:
              begin
                o_lad_oe_n <= 1'b1;
                st_q <= `LFPC_ST_IDLE;
              end
            endcase
          end
          default: st_q <= `LFPC_ST_IDLE;
        endcase
      end
    end
  end

  // standby only when no write is being launched
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_standby <= 1'b1;
      o_pp_active <= 1'b0;
      o_pp_addr <= {2*PP_AW{1'b0}};
    end
    else
    begin
      // held in standby until the synchronised select is trustworthy
      o_standby <= (ce_n_s | ~mode_taken_q) & ~o_wr_start;
      o_pp_active <= mode_taken_q & mode_q;
      if (mode_q)
      begin
        if (rc_n_s)
        begin
          o_pp_addr[2*PP_AW-1:PP_AW] <= ppa_s;
        end
        else
        begin
          o_pp_addr[PP_AW-1:0] <= ppa_s;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== lfpc_props.sv
/* lfpc_props.sv: port assertions for lfpc_top.
   Assumes protection pins stay steady during a write. */
`timescale 1ns/100ps
`default_nettype none
module lfpc_props (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_init_n,
  input wire logic i_ce_n,
  input wire logic i_frame_n,
  input wire logic i_top_block_lock_n,
  input wire logic i_wp_n,
  input wire logic o_lad_oe_n,
  input wire logic o_standby,
  input wire logic o_pp_active,
  input wire logic o_wr_start,
  input wire logic o_wr_refused,
  input wire logic [19:0] o_wr_addr
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n || !i_init_n);
  one_pulse_a: assert property (!(o_wr_start && o_wr_refused))
    else $error("start and refusal");
  prot_pin_a: assert property (o_wr_start |->
    ((o_wr_addr[19:16] == 4'hF) ? $past(i_top_block_lock_n, 4) : $past(i_wp_n, 4)))
    else $error("protected write");
  frame_ok_a: assert property (o_wr_start |->
    $past(i_frame_n, 3) && $past(i_frame_n, 6) && !$past(i_ce_n, 5))
    else $error("unframed write");
  idle_sb_a: assert property (i_ce_n [*5] |-> o_standby || o_wr_start)
    else $error("no standby");
  sel_sb_a: assert property ((!i_ce_n) [*5] |-> !o_standby)
    else $error("standby when selected");
  rd_len_a: assert property ($fell(o_lad_oe_n) |-> !o_lad_oe_n [*3] ##1 o_lad_oe_n)
    else $error("drive length");
  drv_bus_a: assert property (!o_lad_oe_n |-> !o_pp_active && !o_standby)
    else $error("drive out of bus mode");
  pp_quiet_a: assert property (o_pp_active |-> !o_wr_start && !o_wr_refused)
    else $error("bus write in pp mode");
  mode_hold_a: assert property (o_pp_active |=> o_pp_active)
    else $error("mode changed");
endmodule
bind lfpc_top lfpc_props i_lfpc_props (.*);
`default_nettype wire

// ===== lfpc_host.sv
/* lfpc_host.sv: bus host model for select, frame and nibble lines.
   Assumes the bench calls xfer from after a falling edge. */
`timescale 1ns/100ps
`default_nettype none
module lfpc_host (
  input wire logic i_sys_clk,
  output var logic o_ce_n = 1'b1,
  output var logic o_frame_n = 1'b1,
  output var logic [3:0] o_lad = 4'hF
);
  task automatic nib(input logic [3:0] v, input logic f);
    @(negedge i_sys_clk);
    o_frame_n = f;
    o_lad = v;
  endtask
  // cut >= 0 aborts at that address nibble with a bad start
  task automatic xfer(input logic [3:0] st, ct, input logic [31:0] a,
    input logic [7:0] d, input int cut);
    @(negedge i_sys_clk);
    o_ce_n = 1'b0;
    nib(st, 1'b0);
    nib(ct, 1'b1);
    for (int i = 7; i >= 0; i--)
      nib(i == cut ? 4'hF : a[4*i+:4], i != cut);
    if (ct == 4'h6)
    begin
      nib(d[3:0], 1'b1);
      nib(d[7:4], 1'b1);
    end
    // released lines sit at the pull-up level
    repeat (11) nib(4'hF, 1'b1);
    o_ce_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== lfpc_tb.sv
/* lfpc_tb.sv: self-checking bench for lfpc_top.
   Assumes lfpc_host and lfpc_props are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module test_lpc_flash_pin_control;
  logic clk = 1'b0, rst_n = 1'b0, init_n = 1'b1, mode = 1'b0;
  logic tbl = 1'b1, wp = 1'b1, rc = 1'b0, ce_n, frame_n, oe_n, sb, ppact, ws, wr;
  logic [4:0] gpi = 5'h00;
  logic [3:0] strap = 4'h3;
  logic [10:0] ppa = 11'h000;
  logic [31:0] seed = 32'h00000031, x;
  logic [3:0] lad, lad_o, rq[$];
  logic [19:0] wa, got_a;
  logic [7:0] wd, got_d;
  logic [21:0] ppo, n_st = 22'h0, n_rf = 22'h0;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  always #50 clk = ~clk;
  lfpc_host i_lfpc_host (.i_sys_clk(clk), .o_ce_n(ce_n), .o_frame_n(frame_n), .o_lad(lad));
  lfpc_top i_lfpc_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_init_n(init_n),
    .i_programmer_port_mode(mode), .i_ce_n(ce_n), .i_frame_n(frame_n), .i_lad(lad),
    .i_chip_strap(strap), .i_board_inputs(gpi), .i_top_block_lock_n(tbl), .i_wp_n(wp),
    .i_row_col_n(rc), .i_pp_addr(ppa), .o_lad(lad_o), .o_lad_oe_n(oe_n), .o_standby(sb),
    .o_pp_active(ppact), .o_wr_start(ws), .o_wr_addr(wa), .o_wr_data(wd),
    .o_wr_refused(wr), .o_pp_addr(ppo));
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input string n, input logic [21:0] e, g);
    samples_checked++;
    if (e !== g)
    begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // outputs are read on the falling edge, well clear of their updates
  always @(negedge clk)
  begin
    if (ws === 1'b1)
    begin
      n_st = n_st + 1;
      got_a = wa;
      got_d = wd;
    end
    if (wr === 1'b1) n_rf = n_rf + 1;
    if (oe_n === 1'b0) rq.push_back(lad_o);
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      close_out();
    end
  end
  task automatic rs(input logic m);
    rst_n = 1'b0;
    mode = m;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic wr_t(input logic [3:0] st, id, input logic [19:0] a, input int cut);
    logic ok, pr;
    logic [7:0] d;
    d = seed[15:8];
    n_st = 0;
    n_rf = 0;
    i_lfpc_host.xfer(st, 4'h6, {7'h7F, id[3:2], 1'b1, id[1:0], a}, d, cut);
    ok = st == 4'h0 && id == strap && cut < 0 && !mode;
    pr = (a[19:16] == 4'hF) ? !tbl : !wp;
    cmp("start", ok && !pr, n_st);
    cmp("refused", ok && pr, n_rf);
    if (ok && !pr)
    begin
      cmp("addr", a, got_a);
      cmp("data", d, got_d);
    end
  endtask
  task automatic rd_t;
    rq = {};
    x = rnd();
    gpi = x[4:0];
    i_lfpc_host.xfer(4'h0, 4'h4, {7'h7F, strap[3:2], 1'b0, strap[1:0], 20'h0}, 8'h0, -1);
    cmp("nibbles", 3, rq.size());
    cmp("board", {4'h0, gpi[3:0], 3'h0, gpi[4]}, {rq[0], rq[1], rq[2]});
  endtask
  initial
  begin
    rs(1'b0);
    rd_t();
    $display("read done");
    repeat (20)
    begin
      x = rnd();
      tbl = x[0];
      wp = x[1];
      wr_t(x[3:2] == 2'h3 ? 4'hA : 4'h0, x[5:4] == 2'h3 ? 4'h5 : strap,
        {x[6] ? 4'hF : x[19:16], x[15:0]}, x[8:7] == 2'h3 ? int'(x[11:9]) : -1);
      repeat (6) @(negedge clk);
      cmp("standby", 1'b1, sb);
    end
    $display("writes done");
    n_st = 0;
    n_rf = 0;
    fork
      i_lfpc_host.xfer(4'h0, 4'h6, {7'h7F, strap[3:2], 1'b1, strap[1:0], 20'h12345}, 8'h5A, -1);
      begin
        repeat (5) @(negedge clk);
        init_n = 1'b0;
        repeat (3) @(negedge clk);
        init_n = 1'b1;
      end
    join
    cmp("init abort", 0, n_st + n_rf);
    rd_t();
    $display("init done");
    rs(1'b1);
    cmp("pp mode", 1'b1, ppact);
    x = rnd();
    rc = 1'b1;
    ppa = x[10:0];
    repeat (4) @(negedge clk);
    rc = 1'b0;
    ppa = x[21:11];
    repeat (4) @(negedge clk);
    cmp("pp addr", {x[10:0], x[21:11]}, ppo);
    wr_t(4'h0, strap, 20'h00100, -1);
    $display("programmer done");
    close_out();
  end
endmodule
`default_nettype wire
